// File: gdhi_ahb_slave.v
`timescale 1ns/1ps
`include "gdhi_map.vh"
module gdhi_ahb_slave (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave side
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // register file side
  output wire wr_en,
  output wire [7:0] wr_addr,
  output wire [31:0] wr_data,
  output wire [7:0] rd_addr,
  input wire [31:0] rd_data
);
  reg wr_pend;
  reg [7:0] wr_addr_q;
  wire take;

  // address phase accepted: nonseq or seq whole-word transfers only
  assign take = hsel & hready & htrans[1] & (hsize == 3'h2);
  assign wr_en = wr_pend;
  assign wr_addr = wr_addr_q;
  assign wr_data = hwdata;
  assign rd_addr = haddr;

  // zero wait state; read data registered at address phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr_q <= 8'h00;
      hreadyout <= 1'b1;
      hrdata <= 32'h00000000;
      hresp <= `GDHI_HRESP_OKAY;
    end else begin
      wr_pend <= take & hwrite;
      if (take)
        wr_addr_q <= haddr;
      if (take & ~hwrite)
        hrdata <= rd_data;
      hreadyout <= 1'b1;
      hresp <= `GDHI_HRESP_OKAY;
    end
  end
endmodule // gdhi_ahb_slave

// File: gdhi_bus_model.sv
`timescale 1ns/1ps
module gdhi_bus_model (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // role and start
  input wire talk,
  input wire go,
  // device lines
  input wire dav_out,
  input wire nrfd_out,
  input wire ndac_out,
  // far side drives, 1 asserts
  output reg dav,
  output reg nrfd,
  output reg ndac
);
  // talker sends one byte, listener accepts at once
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dav <= 1'b0;
      nrfd <= 1'b0;
      ndac <= 1'b0;
    end else begin
      nrfd <= !talk && dav_out;
      ndac <= !talk && !dav_out;
      if (dav && !ndac_out)
        dav <= 1'b0;
      else if (talk && go && !dav && !nrfd_out)
        dav <= 1'b1;
    end
  end
endmodule // gdhi_bus_model

// File: gdhi_debounce.v
`timescale 1ns/1ps
`include "gdhi_map.vh"
module gdhi_debounce #(
  parameter SAMPLES = `GDHI_DEBOUNCE_SAMPLES
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // raw and filtered level
  input wire raw,
  output reg clean
);
  reg [7:0] count;

  // output follows only after SAMPLES equal samples, both edges
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 8'h00;
      clean <= 1'b0;
    end else if (raw == clean) begin
      count <= 8'h00;
    end else if (count == SAMPLES[7:0] - 8'h01) begin
      count <= 8'h00;
      clean <= raw; // [R6] [R22]
    end else begin
      count <= count + 8'h01; // [R22]
    end
  end
endmodule // gdhi_debounce

// File: gdhi_map.vh
`ifndef GDHI_MAP_VH
`define GDHI_MAP_VH

// register byte offsets
`define GDHI_OFS_CTRL 8'h00
`define GDHI_OFS_STATUS 8'h04
`define GDHI_OFS_TXDATA 8'h08
`define GDHI_OFS_RXDATA 8'h0C
`define GDHI_OFS_EVENT 8'h10

// control register fields
`define GDHI_CTRL_ADVANCE 0
`define GDHI_CTRL_ADDRESSED 1
`define GDHI_CTRL_EOI 2
`define GDHI_CTRL_SRQ 3
`define GDHI_CTRL_TALK 4
`define GDHI_CTRL_RESET 5'h00

// status port fields
`define GDHI_STAT_ATN 7
`define GDHI_STAT_EOI 6
`define GDHI_STAT_NOLSN 5

// event register fields
`define GDHI_EVT_HAND 0
`define GDHI_EVT_IFC 1
`define GDHI_EVT_ATN 2

// debounce depth in clock samples
`define GDHI_DEBOUNCE_SAMPLES 4

// ahb constants
`define GDHI_HTRANS_NONSEQ 2'h2
`define GDHI_HRESP_OKAY 1'h0

`endif

// File: gdhi_top.v
// How it works
// R1: status port: attention, eoi, no-listener, five switches
// R2: listen_talk_select low listens, high talks
// R3: data drivers only in talk, attention inactive
// R4: transmit and receive latches always enabled
// R5: source handshake output only in talk mode
// R6: debounce attention, clear, ndac, handshake-ready both edges
// R7: no-listener flag when neither nrfd nor ndac
// R8: ready: listen with dav, or talk without nrfd
// R9: debounced ready sets processor event bit
// R10: source flop set in listen or data-accepted
// R11: advance strobe in talk clears flop, drives dav
// R12: gate blocks dav while listening
// R13: acceptor enabled unless talking, or attention active
// R14: release nrfd only when enabled and dav false
// R15: dav true asserts nrfd at once
// R16: hold nrfd until dav gone, ready low
// R17: hold ndac until advance strobe releases it
// R18: talker sends next byte after ndac released
// R19: handshake drivers only when addressed or attention
// R20: control bits: advance, addressed, eoi, srq, select
// R21: control cleared by restart or interface clear
// R22: filter changes after several steady samples
// R23: advance strobe is one-cycle write pulse
`timescale 1ns/1ps
`include "gdhi_map.vh"
module gdhi_top #(
  parameter DEBOUNCE = `GDHI_DEBOUNCE_SAMPLES
) (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite register bus
  input wire hsel,
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire [31:0] hrdata,
  output wire hresp,
  // bus data lines, message-true high
  input wire [7:0] dio_in,
  output reg [7:0] dio_out,
  output reg dio_oe,
  // handshake lines and eoi, message-true high
  input wire dav_in,
  output reg dav_out,
  input wire nrfd_in,
  output reg nrfd_out,
  input wire ndac_in,
  output reg ndac_out,
  input wire eoi_in,
  output reg eoi_out,
  output reg handshake_oe,
  // management lines
  input wire atn_in,
  input wire ifc_in,
  output reg srq_out,
  output reg srq_oe,
  // address switch and event output
  input wire [4:0] address_switch,
  output reg event_irq
);
  // control and data registers
  reg [4:1] ctrl;
  reg handshake_advance;
  reg [7:0] tx_latch;
  reg [7:0] rx_latch;
  reg eoi_seen;
  reg no_listener_flag;
  reg [2:0] events;

  // handshake state and edge history
  reg source_handshake;
  reg nrfd_hold;
  reg ndac_hold;
  reg hand_prev;
  reg atn_prev;

  // register slave side
  reg [31:0] rd_data;
  wire wr_en;
  wire [7:0] wr_addr;
  wire [31:0] wr_data;
  wire [7:0] rd_addr;

  // filtered lines
  wire [3:0] raw_lines;
  wire [3:0] clean_lines;
  wire debounced_attention;
  wire debounced_interface_clear;
  wire debounced_ndac;
  wire debounced_handshake_ready;

  // steering, write decode and event terms
  wire talk;
  wire acceptor_enable;
  wire handshake_ready;
  wire ctrl_wr;
  wire tx_wr;
  wire evt_wr;
  wire hand_rise;
  wire atn_change;
  wire [2:0] evt_set;
  wire [2:0] evt_clr;

  // register slave
  gdhi_ahb_slave u_bus (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .hreadyout(hreadyout),
    .hrdata(hrdata),
    .hresp(hresp),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .rd_addr(rd_addr),
    .rd_data(rd_data)
  );

  // mode steering terms
  assign talk = ctrl[`GDHI_CTRL_TALK]; // [R2]
  assign acceptor_enable = ~talk | atn_in; // [R13]
  // ready gating: listen side uses dav, talk side nrfd
  assign handshake_ready = acceptor_enable ? dav_in : ~nrfd_in; // [R8]

  // four debounce filters
  assign raw_lines = {handshake_ready, ndac_in, ifc_in, atn_in};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_deb
      gdhi_debounce #(
        .SAMPLES(DEBOUNCE)
      ) u_deb (
        .hclk(hclk),
        .hresetn(hresetn),
        .raw(raw_lines[gi]),
        .clean(clean_lines[gi])
      ); // [R6]
    end
  endgenerate

  // filter outputs, one per line
  assign debounced_attention = clean_lines[0];
  assign debounced_interface_clear = clean_lines[1];
  assign debounced_ndac = clean_lines[2];
  assign debounced_handshake_ready = clean_lines[3];

  // data-phase write hit on one register offset
  function wr_hit;
    input en;
    input [7:0] addr;
    input [7:0] ofs;
    begin
      wr_hit = en & (addr == ofs);
    end
  endfunction

  // register write decodes
  assign ctrl_wr = wr_hit(wr_en, wr_addr, `GDHI_OFS_CTRL);
  assign tx_wr = wr_hit(wr_en, wr_addr, `GDHI_OFS_TXDATA);
  assign evt_wr = wr_hit(wr_en, wr_addr, `GDHI_OFS_EVENT);

  // control register, cleared by restart or interface clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl <= 4'h0;
      handshake_advance <= 1'b0;
    end else if (debounced_interface_clear) begin
      ctrl <= 4'h0; // [R21]
      handshake_advance <= 1'b0;
    end else begin
      handshake_advance <= ctrl_wr & wr_data[`GDHI_CTRL_ADVANCE]; // [R23]
      if (ctrl_wr)
        ctrl <= wr_data[4:1]; // [R20]
    end
  end

  // transmit latch and always-open receive path
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_latch <= 8'h00;
      rx_latch <= 8'h00;
      dio_out <= 8'h00;
      dio_oe <= 1'b0;
    end else begin
      if (tx_wr)
        tx_latch <= wr_data[7:0];
      rx_latch <= dio_in; // [R4]
      dio_out <= tx_latch; // [R4]
      dio_oe <= talk & ~atn_in; // [R3]
    end
  end

  // source handshake flop: listen or accepted sets, advance clears
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      source_handshake <= 1'b1;
    end else if (~talk) begin
      source_handshake <= 1'b1; // [R10]
    end else if (handshake_advance) begin
      source_handshake <= 1'b0; // [R11]
    end else if (~debounced_ndac) begin
      source_handshake <= 1'b1; // [R10]
    end
  end

  // acceptor handshake: nrfd hold and ndac hold
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      nrfd_hold <= 1'b0;
      ndac_hold <= 1'b1;
    end else begin
      if (acceptor_enable & dav_in)
        nrfd_hold <= 1'b1; // [R15]
      else if (~dav_in & ~debounced_handshake_ready)
        nrfd_hold <= 1'b0; // [R16]
      if (handshake_advance & dav_in)
        ndac_hold <= 1'b0; // [R17]
      else if (~dav_in)
        ndac_hold <= 1'b1; // [R17] [R18]
    end
  end

  // handshake line drivers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dav_out <= 1'b0;
      nrfd_out <= 1'b0;
      ndac_out <= 1'b0;
      handshake_oe <= 1'b0;
    end else begin
      dav_out <= talk & ~source_handshake; // [R5] [R11] [R12]
      nrfd_out <= acceptor_enable & (dav_in | nrfd_hold); // [R14] [R15]
      ndac_out <= acceptor_enable & ndac_hold; // [R17]
      handshake_oe <= ctrl[`GDHI_CTRL_ADDRESSED] | atn_in; // [R19]
    end
  end

  // eoi and service request drivers
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      eoi_out <= 1'b0;
      srq_out <= 1'b0;
      srq_oe <= 1'b0;
    end else begin
      eoi_out <= talk & ctrl[`GDHI_CTRL_EOI]; // only sent while talking
      srq_out <= ctrl[`GDHI_CTRL_SRQ];
      srq_oe <= ctrl[`GDHI_CTRL_SRQ];
    end
  end

  // status port sources
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      no_listener_flag <= 1'b0;
      eoi_seen <= 1'b0;
    end else begin
      no_listener_flag <= ~nrfd_in & ~ndac_in; // [R7]
      eoi_seen <= eoi_in;
    end
  end

  // event sources: ready rise, clear level, attention change
  assign hand_rise = debounced_handshake_ready & ~hand_prev; // [R9]
  assign atn_change = debounced_attention ^ atn_prev;
  assign evt_set = {atn_change, debounced_interface_clear, hand_rise};
  assign evt_clr = evt_wr ? wr_data[2:0] : 3'h0;

  // sticky events: set wins over write-one clear
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      events <= 3'h0;
      hand_prev <= 1'b0;
      atn_prev <= 1'b0;
      event_irq <= 1'b0;
    end else begin
      hand_prev <= debounced_handshake_ready;
      atn_prev <= debounced_attention;
      events <= (events & ~evt_clr) | evt_set; // [R9]
      event_irq <= |events; // [R9]
    end
  end

  // read mux, unmapped reads zero
  always @* begin
    case (rd_addr)
      `GDHI_OFS_CTRL: rd_data = {27'h0000000, ctrl, 1'b0};
      `GDHI_OFS_STATUS: rd_data = {24'h000000, debounced_attention,
                                   eoi_seen, no_listener_flag,
                                   address_switch}; // [R1]
      `GDHI_OFS_TXDATA: rd_data = {24'h000000, tx_latch};
      `GDHI_OFS_RXDATA: rd_data = {24'h000000, rx_latch};
      `GDHI_OFS_EVENT: rd_data = {29'h00000000, events};
      default: rd_data = 32'h00000000;
    endcase
  end
endmodule // gdhi_top

// File: gdhi_top_monitor.sv
`timescale 1ns/1ps
module gdhi_top_monitor (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // register bus
  input wire [7:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire [31:0] hrdata,
  // bus side
  input wire dio_oe,
  input wire dav_in,
  input wire dav_out,
  input wire nrfd_out,
  input wire ndac_out,
  input wire atn_in,
  input wire ifc_in,
  input wire srq_out,
  input wire [4:0] address_switch,
  input wire event_irq
);
  reg ctrl_ph;
  wire adv;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // control write in its data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn)
      ctrl_ph <= 1'b0;
    else
      ctrl_ph <= htrans[1] && hwrite && haddr == 8'h00;
  end
  assign adv = ctrl_ph && hwdata[0];
  // status read and byte arrival
  sequence s_rd_stat;
    htrans[1] && !hwrite && haddr == 8'h04;
  endsequence
  sequence s_dav_up;
    $rose(dav_in) && atn_in;
  endsequence
  a_status_read: assert property (
    s_rd_stat |=> hrdata[4:0] == $past(address_switch) &&
      hrdata[31:8] == 24'h000000)
    else $error("status read lost switch bits");
  a_data_drive_off: assert property (atn_in |=> !dio_oe)
    else $error("data drivers on under attention");
  a_nrfd_on_dav: assert property (atn_in && dav_in |=> nrfd_out)
    else $error("nrfd not raised on dav");
  a_nrfd_hold_on: assert property (
    nrfd_out && dav_in && atn_in |=> nrfd_out)
    else $error("nrfd released while dav true");
  a_ndac_release: assert property (
    $fell(ndac_out) && dav_in && atn_in |->
      $past(adv, 2) || $past(adv, 3) || $past(adv, 4))
    else $error("ndac released without advance");
  a_ready_event: assert property (s_dav_up |-> ##[1:12] event_irq)
    else $error("no event after dav");
  a_talk_dav: assert property (adv && dio_oe |-> ##[1:5] dav_out)
    else $error("advance in talk gave no dav");
  a_ifc_clear: assert property (ifc_in [*8] |-> !srq_out)
    else $error("interface clear left srq set");
endmodule // gdhi_top_monitor

bind gdhi_top gdhi_top_monitor u_mon (
  .hclk, .hresetn, .haddr, .htrans, .hwrite, .hwdata, .hrdata,
  .dio_oe, .dav_in, .dav_out, .nrfd_out, .ndac_out, .atn_in, .ifc_in,
  .srq_out, .address_switch, .event_irq
);

// File: gdhi_top_test.sv
`timescale 1ns/1ps
module gdhi_top_test;
  reg hclk, hresetn, hwrite, atn_in, ifc_in, eoi_in, m_talk, m_go;
  reg [1:0] htrans;
  reg [7:0] haddr, dio_in;
  reg [31:0] hwdata, rd;
  integer err_total, cmp_count, cyc;
  wire hreadyout, hresp, dio_oe, dav_out, nrfd_out, ndac_out, eoi_out;
  wire handshake_oe, srq_out, srq_oe, event_irq, m_dav, m_nrfd, m_ndac;
  wire [31:0] hrdata;
  wire [7:0] dio_out;
  // wired-or bus lines
  wire dav_in = m_dav | dav_out & handshake_oe;
  wire nrfd_in = m_nrfd | nrfd_out & handshake_oe;
  wire ndac_in = m_ndac | ndac_out & handshake_oe;

  gdhi_top u_dut (
    .hclk, .hresetn, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata,
    .hresp, .dio_in, .dio_out, .dio_oe, .dav_in, .dav_out, .nrfd_in,
    .nrfd_out, .ndac_in, .ndac_out, .eoi_in, .eoi_out, .handshake_oe,
    .atn_in, .ifc_in, .srq_out, .srq_oe, .address_switch(5'h15),
    .event_irq
  );
  gdhi_bus_model u_far (
    .hclk, .hresetn, .talk(m_talk), .go(m_go), .dav_out, .nrfd_out,
    .ndac_out, .dav(m_dav), .nrfd(m_nrfd), .ndac(m_ndac)
  );

  // compare and count
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // one ahb single transfer
  task xfer(input [7:0] a, input w, input [31:0] d);
    begin
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1) @(posedge hclk);
      rd = hrdata;
    end
  endtask
  task rdc(input [7:0] a, input [31:0] e);
    begin
      xfer(a, 1'b0, 32'h0);
      chk(rd, e);
      chk(hresp, 1'b0);
    end
  endtask
  task final_report;
    begin
      $display("errors %0d checks %0d", err_total, cmp_count);
      if (err_total == 0 && cmp_count > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask

  // clock
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // hang guard
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      final_report;
    end
  end
  // main sequence
  initial begin
    {hresetn, hwrite, atn_in, ifc_in, eoi_in, m_go} = 6'h00;
    {htrans, haddr, dio_in, hwdata} = 50'h0;
    {err_total, cmp_count, cyc} = 0;
    m_talk = 1'b1;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(8'h00, 32'h0);
    rdc(8'h04, 32'h35);
    m_talk <= 1'b0;
    eoi_in <= 1'b1;
    repeat (2) @(posedge hclk);
    rdc(8'h04, 32'h55);
    atn_in <= 1'b1;
    repeat (2) @(posedge hclk);
    atn_in <= 1'b0;
    repeat (8) @(posedge hclk);
    rdc(8'h10, 32'h0);
    xfer(8'h00, 1'b1, 32'h0F);
    rdc(8'h00, 32'h0E);
    chk(srq_out, 1'b1);
    chk(srq_oe, 1'b1);
    rdc(8'h20, 32'h0);
    ifc_in <= 1'b1;
    repeat (10) @(posedge hclk);
    rdc(8'h00, 32'h0);
    rdc(8'h10, 32'h2);
    ifc_in <= 1'b0;
    repeat (8) @(posedge hclk);
    xfer(8'h10, 1'b1, 32'h7);
    rdc(8'h10, 32'h0);
    chk(event_irq, 1'b0);
    // listen transfer under attention
    atn_in <= 1'b1;
    dio_in <= 8'hA5;
    repeat (8) @(posedge hclk);
    xfer(8'h10, 1'b1, 32'h7);
    repeat (2) @(posedge hclk);
    chk(handshake_oe, 1'b1);
    chk(dio_oe, 1'b0);
    chk(nrfd_out, 1'b0);
    m_talk <= 1'b1;
    m_go <= 1'b1;
    wait (event_irq === 1'b1);
    @(posedge hclk);
    m_go <= 1'b0;
    chk(nrfd_out, 1'b1);
    chk(ndac_out, 1'b1);
    rdc(8'h0C, 32'hA5);
    rdc(8'h10, 32'h1);
    xfer(8'h00, 1'b1, 32'h1);
    wait (dav_in === 1'b0);
    chk(nrfd_out, 1'b1);
    wait (nrfd_out === 1'b0);
    @(posedge hclk);
    chk(ndac_out, 1'b1);
    atn_in <= 1'b0;
    // talk transfer
    m_talk <= 1'b0;
    xfer(8'h08, 1'b1, 32'h3C);
    xfer(8'h00, 1'b1, 32'h16);
    repeat (2) @(posedge hclk);
    chk(dio_oe, 1'b1);
    chk(dio_out, 32'h3C);
    chk(dav_out, 1'b0);
    chk(eoi_out, 1'b1);
    xfer(8'h00, 1'b1, 32'h17);
    wait (dav_out === 1'b1);
    chk(dav_in, 1'b1);
    wait (dav_out === 1'b0);
    @(posedge hclk);
    xfer(8'h00, 1'b1, 32'h02);
    xfer(8'h00, 1'b1, 32'h03);
    repeat (4) @(posedge hclk);
    chk(dav_out, 1'b0);
    final_report;
  end
endmodule // gdhi_top_test
